// ===== verilog/mdio_uac_regs.vh
/*
  Register offsets, field positions, reset values and timing counts of the
  second management user-access channel.
  Assumes a 250 MHz system clock and byte addresses on an APB bus.
*/
`ifndef MDIO_UAC_REGS_VH
`define MDIO_UAC_REGS_VH

// --------------------------------------------------------------------
// Register byte offsets
// --------------------------------------------------------------------
`define OFS_CMD 8'h00
`define OFS_SEL 8'h04
`define OFS_CTRL 8'h08
`define OFS_IRQ_STAT 8'h0c
`define OFS_IRQ_MASK 8'h10
`define OFS_LINK 8'h14

// --------------------------------------------------------------------
// Field positions
// --------------------------------------------------------------------
`define CMD_GO 31
`define CMD_WR 30
`define CMD_ACK 29
`define CMD_REG_MSB 25
`define CMD_REG_LSB 21
`define CMD_PHY_MSB 20
`define CMD_PHY_LSB 16
`define SEL_LINK_SRC 7
`define SEL_IRQ_EN 6
`define SEL_MON_MSB 4
`define CTRL_ENABLE 0
`define IRQ_DONE 0
`define IRQ_LINK 1
`define IRQ_W 2

// --------------------------------------------------------------------
// Reset values
// --------------------------------------------------------------------
`define CMD_RST 32'h0000_0000
`define SEL_RST 8'h00
`define IRQ_RST 2'h0

// --------------------------------------------------------------------
// Frame layout and link polling
// --------------------------------------------------------------------
`define PRE_BITS 6'h20
`define LAST_BIT 6'h3f
`define DRV_END 6'h2e
`define ACK_BIT 6'h2f
`define DATA_FIRST 6'h30
`define OP_READ 2'h2
`define OP_WRITE 2'h1
`define POLL_REG 5'h01
`define POLL_LINK_BIT 2

// --------------------------------------------------------------------
// Timing
// --------------------------------------------------------------------
`define CLK_NS 4
`define MDC_HALF_NS 200
`define MDC_HALF_CYC ((`MDC_HALF_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ===== verilog/mdio_bit_sync.v
/*
  Two-stage synchroniser for the serial data pin.
  Assumes the pin is asynchronous to i_clk_sys.
*/
`timescale 1ns/100ps
`default_nettype none

module mdio_bit_sync (
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_async,
  output wire o_sync
);

  reg meta_q;
  reg sync_q;

  // Only the second stage is read by logic.
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule

`default_nettype wire

// ===== verilog/mdc_divider.v
/*
  Management clock divider: toggles the serial clock every half period
  and flags the system cycle on which each edge occurs.
  Assumes the half period count from the register header.
*/
`timescale 1ns/100ps
`default_nettype none
`include "mdio_uac_regs.vh"

module mdc_divider (
  input wire i_clk_sys,
  input wire i_rst,
  output wire o_mdc,
  output wire o_rise,
  output wire o_fall
);

  // Half period count less one as an integer, cut to the counter's width on purpose.
  localparam integer HALF_INT = `MDC_HALF_CYC - 1;
  localparam [7:0] HALF_M1 = HALF_INT[7:0];

  reg [7:0] cnt_q;
  reg mdc_q;

  // Free-running half-period counter and clock toggle.
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= 8'h00;
      mdc_q <= 1'b0;
    end else if (cnt_q == HALF_M1) begin
      cnt_q <= 8'h00;
      mdc_q <= ~mdc_q;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // Edge flags mark the cycle on which the clock flips.
  assign o_rise = (cnt_q == HALF_M1) && !mdc_q;
  assign o_fall = (cnt_q == HALF_M1) && mdc_q;
  assign o_mdc = mdc_q;

endmodule

`default_nettype wire

// ===== verilog/mdio_user_access_channel.v
/*
  Second user-access channel of a management serial controller: APB
  registers, a frame engine for clause 22 read and write frames, link
  polling of one monitored PHY and a masked level interrupt.
  Assumes an APB master on i_clk_sys and PHYs on a shared data pin.
  Assumes the monitored PHY reports its link state in register 1.
*/
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "mdio_uac_regs.vh"

module mdio_user_access_channel (
  input wire i_clk_sys,
  input wire i_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  output wire o_irq,
  output wire o_mdc,
  input wire i_mdio,
  output wire o_mdio,
  output wire o_mdio_oe_n
);

  // Engine states: idle between frames, or shifting one frame.
  localparam S_IDLE = 1'b0;
  localparam S_FRAME = 1'b1;

  // ------------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------------

  // True for every mapped register offset.
  function hit;
    input [7:0] a;
    begin
      hit = (a == `OFS_CMD) || (a == `OFS_SEL) || (a == `OFS_CTRL) ||
            (a == `OFS_IRQ_STAT) || (a == `OFS_IRQ_MASK) || (a == `OFS_LINK);
    end
  endfunction

  // Register contents, engine state and the pin flops.
  reg [31:0] cmd_q;
  reg [7:0] sel_q;
  reg enable_q;
  reg [`IRQ_W-1:0] irq_stat_q;
  reg [`IRQ_W-1:0] irq_mask_q;
  reg link_q;
  reg [31:0] prdata_q;
  reg state_q;
  reg user_q;
  reg rd_q;
  reg [5:0] cnt_q;
  reg [31:0] frame_q;
  reg [15:0] rdata_q;
  reg ack_q;
  reg mdio_q;
  reg oe_n_q;
  reg done_q;

  // Internal strobes and decoded fields.
  wire mdio_s;
  wire mdc_rise;
  wire mdc_fall;
  wire wr_acc;
  wire setup;
  wire last_rise;
  wire [`IRQ_W-1:0] irq_set;
  wire link_new;
  wire link_diff;
  wire [4:0] mon_phy;

  // ------------------------------------------------------------------
  // Submodules
  // ------------------------------------------------------------------

  // The data pin is resynchronised before the engine samples it.
  mdio_bit_sync u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_async(i_mdio),
    .o_sync(mdio_s)
  );

  // The serial clock is derived from the system clock.
  mdc_divider u_div (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .o_mdc(o_mdc),
    .o_rise(mdc_rise),
    .o_fall(mdc_fall)
  );

  // ------------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------------

  // Zero-wait access phase; read data is latched in the setup cycle.
  // Unmapped offsets answer with an error and read as zero.
  assign setup = i_psel && !i_penable;
  assign wr_acc = i_psel && i_penable && i_pwrite && hit(i_paddr);
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !hit(i_paddr);
  assign o_prdata = prdata_q;

  // Read multiplexer sampled at the setup cycle.
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !i_pwrite) begin
      case (i_paddr)
        `OFS_CMD: prdata_q <= cmd_q;
        `OFS_SEL: prdata_q <= {24'h00_0000, sel_q};
        `OFS_CTRL: prdata_q <= {31'h0000_0000, enable_q};
        `OFS_IRQ_STAT: prdata_q <= {30'h0000_0000, irq_stat_q};
        `OFS_IRQ_MASK: prdata_q <= {30'h0000_0000, irq_mask_q};
        `OFS_LINK: prdata_q <= {30'h0000_0000, state_q, link_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Command register
  // ------------------------------------------------------------------

  // Software writes, go handling and completion write-back.
  // Completion wins over a write; a clash cannot arise because writes
  // are refused while go is set.
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cmd_q <= `CMD_RST;
    end else if (done_q && user_q) begin
      cmd_q[`CMD_GO] <= 1'b0;
      if (rd_q) begin
        cmd_q[15:0] <= rdata_q;
        cmd_q[`CMD_ACK] <= ack_q;
      end
    end else if (wr_acc && (i_paddr == `OFS_CMD) && !cmd_q[`CMD_GO]) begin
      cmd_q[30:29] <= i_pwdata[30:29];
      cmd_q[25:0] <= i_pwdata[25:0];
      if (i_pwdata[`CMD_GO] && enable_q) begin
        cmd_q[`CMD_GO] <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Select, control and mask registers
  // ------------------------------------------------------------------

  // Plain storage; the link source bit is held at zero.
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sel_q <= `SEL_RST;
      enable_q <= 1'b0;
      irq_mask_q <= `IRQ_RST;
    end else if (wr_acc) begin
      if (i_paddr == `OFS_SEL) begin
        sel_q[`SEL_LINK_SRC] <= 1'b0;
        sel_q[`SEL_IRQ_EN] <= i_pwdata[`SEL_IRQ_EN];
        sel_q[4:0] <= i_pwdata[4:0];
      end
      if (i_paddr == `OFS_CTRL) begin
        enable_q <= i_pwdata[`CTRL_ENABLE];
      end
      if (i_paddr == `OFS_IRQ_MASK) begin
        irq_mask_q <= i_pwdata[`IRQ_W-1:0];
      end
    end
  end

  // The monitored PHY address feeds every poll frame.
  assign mon_phy = sel_q[`SEL_MON_MSB:0];

  // ------------------------------------------------------------------
  // Frame engine
  // ------------------------------------------------------------------

  // Rising serial edge that samples the final data bit.
  assign last_rise = mdc_rise && (cnt_q == `LAST_BIT);

  // Starts a user frame first, else a link poll when enabled; each frame
  // is 32 preamble ones, start, opcode, addresses, turnaround and data.
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_q <= S_IDLE;
      user_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 6'h00;
      frame_q <= 32'h0000_0000;
      rdata_q <= 16'h0000;
      ack_q <= 1'b0;
      mdio_q <= 1'b1;
      oe_n_q <= 1'b1;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (mdc_fall) begin
            oe_n_q <= 1'b1;
          end
          if (mdc_rise && !done_q && cmd_q[`CMD_GO]) begin
            state_q <= S_FRAME;
            user_q <= 1'b1;
            cnt_q <= 6'h00;
            ack_q <= 1'b0;
            rd_q <= !cmd_q[`CMD_WR];
            frame_q <= {2'b01,
                        cmd_q[`CMD_WR] ? `OP_WRITE : `OP_READ,
                        cmd_q[`CMD_PHY_MSB:`CMD_PHY_LSB],
                        cmd_q[`CMD_REG_MSB:`CMD_REG_LSB],
                        2'b10, cmd_q[15:0]};
          end else if (mdc_rise && !done_q && enable_q) begin
            state_q <= S_FRAME;
            user_q <= 1'b0;
            cnt_q <= 6'h00;
            ack_q <= 1'b0;
            rd_q <= 1'b1;
            frame_q <= {2'b01, `OP_READ, mon_phy, `POLL_REG, 2'b10, 16'h0000};
          end
        end
        S_FRAME: begin
          if (mdc_fall) begin
            oe_n_q <= rd_q && (cnt_q >= `DRV_END);
            if (cnt_q < `PRE_BITS) begin
              mdio_q <= 1'b1;
            end else begin
              mdio_q <= frame_q[31];
              frame_q <= {frame_q[30:0], 1'b0};
            end
          end
          if (mdc_rise) begin
            if (rd_q && (cnt_q == `ACK_BIT)) begin
              ack_q <= !mdio_s;
            end
            if (rd_q && (cnt_q >= `DATA_FIRST)) begin
              rdata_q <= {rdata_q[14:0], mdio_s};
            end
            cnt_q <= cnt_q + 6'h01;
          end
          if (last_rise) begin
            state_q <= S_IDLE;
            done_q <= 1'b1;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // Pin outputs come straight from flops, so they move only on the
  // system cycle of a falling serial edge.
  assign o_mdio = mdio_q;
  assign o_mdio_oe_n = oe_n_q;

  // ------------------------------------------------------------------
  // Link tracking
  // ------------------------------------------------------------------

  // Link bit of the last poll and the change that it reports.
  assign link_new = rdata_q[`POLL_LINK_BIT];
  assign link_diff = done_q && !user_q && ack_q && (link_new != link_q);

  // Records the link bit of each acknowledged poll.
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      link_q <= 1'b0;
    end else if (link_diff) begin
      link_q <= link_new;
    end
  end

  // ------------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------------

  // Event strobes: a finished user access and a reported link change.
  // link change gated by the select interrupt enable
  assign irq_set[`IRQ_LINK] = link_diff && sel_q[`SEL_IRQ_EN];
  assign irq_set[`IRQ_DONE] = done_q && user_q;

  // Sticky status, write one to clear; a new event wins over the clear.
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      irq_stat_q <= `IRQ_RST;
    end else if (wr_acc && (i_paddr == `OFS_IRQ_STAT)) begin
      irq_stat_q <= (irq_stat_q & ~i_pwdata[`IRQ_W-1:0]) | irq_set;
    end else begin
      irq_stat_q <= irq_stat_q | irq_set;
    end
  end

  assign o_irq = |(irq_stat_q & irq_mask_q);

endmodule

`default_nettype wire

// ===== sim/mdio_uac_props.sv
/* Port checker for the user-access channel.
   Assumes a bind onto the channel's top module. */
`timescale 1ns/100ps
`default_nettype none
`include "mdio_uac_regs.vh"
module mdio_uac_props (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_irq,
  input wire logic o_mdc,
  input wire logic o_mdio,
  input wire logic o_mdio_oe_n
);
  localparam int HALF = `MDC_HALF_CYC;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  logic wr, rd, mdc_q, seen_q, en_q, ien_q;
  logic [6:0] run_q;
  // Access phase decode.
  assign wr = i_psel && i_penable && i_pwrite;
  assign rd = i_psel && i_penable && !i_pwrite;
  // Clock run length and whether the enables were ever written.
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      mdc_q <= 1'b0;
      seen_q <= 1'b0;
      run_q <= 7'd0;
      en_q <= 1'b0;
      ien_q <= 1'b0;
    end else begin
      mdc_q <= o_mdc;
      seen_q <= seen_q | (o_mdc != mdc_q);
      run_q <= (o_mdc != mdc_q) ? 7'd0 : run_q + 7'd1;
      en_q <= en_q | (wr && i_paddr == `OFS_CTRL && i_pwdata[`CTRL_ENABLE]);
      ien_q <= ien_q | (wr && i_paddr == `OFS_SEL && i_pwdata[`SEL_IRQ_EN]);
    end
  end
  chk_mdc_half_period: assert property (seen_q && o_mdc != mdc_q |-> run_q == HALF - 1)
    else $error("serial clock half period wrong");
  chk_oe_on_low: assert property ($changed(o_mdio_oe_n) |-> !o_mdc)
    else $error("pin enable changed while clock high");
  chk_data_on_low: assert property (!o_mdio_oe_n && $changed(o_mdio) |-> !o_mdc)
    else $error("pin data changed while clock high");
  chk_sel_reserved: assert property (rd && i_paddr == `OFS_SEL |-> o_prdata[31:7] == 25'h0)
    else $error("select register upper bits not zero");
  chk_cmd_reserved: assert property (rd && i_paddr == `OFS_CMD |-> o_prdata[28:26] == 3'h0)
    else $error("command reserved bits not zero");
  chk_go_needs_enable: assert property (rd && i_paddr == `OFS_CMD && !en_q |-> !o_prdata[31])
    else $error("go set while engine never enabled");
  chk_no_link_event: assert property (rd && i_paddr == `OFS_IRQ_STAT && !ien_q |-> !o_prdata[1])
    else $error("link event without enable");
  chk_irq_masked_off: assert property (wr && i_paddr == `OFS_IRQ_MASK && i_pwdata[1:0] == 2'h0 |=> !o_irq)
    else $error("interrupt high with all masked");
endmodule
`default_nettype wire

// ===== sim/phy_model.sv
/* Behavioural PHY: one address, 32 registers, link bit in register 1.
   Assumes the bench resolves the pulled-up data pin. */
`timescale 1ns/100ps
`default_nettype none
module phy_model #(parameter logic [4:0] ADR = 5'h01) (
  input wire logic i_mdc,
  input wire logic i_wire,
  input wire logic i_link,
  output logic o_drive,
  output logic o_data
);
  logic [15:0] mem [0:31];
  logic [15:0] rv, sh;
  logic [11:0] hdr;
  logic [6:0] cnt;
  logic [32:0] win;
  // Read value, with the live link level in register 1.
  assign rv = (hdr[4:0] == 5'h01) ? {mem[1][15:3], i_link, mem[1][1:0]} : mem[hdr[4:0]];
  initial begin
    foreach (mem[i]) mem[i] = 16'h0000;
    {o_drive, o_data, sh, hdr, cnt, win} = '0;
  end
  always @(posedge i_mdc) begin
    win <= {win[31:0], i_wire};
    if (cnt == 7'd0) begin
      if ({win, i_wire} == {32'hffff_ffff, 2'b01}) cnt <= 7'd34;
    end else begin
      if (cnt < 7'd46) hdr <= {hdr[10:0], i_wire};
      if (cnt >= 7'd48) sh <= {sh[14:0], i_wire};
      cnt <= (cnt == 7'd63) ? 7'd0 : cnt + 7'd1;
      if (cnt == 7'd63 && hdr[11:5] == {2'b01, ADR}) mem[hdr[4:0]] <= {sh[14:0], i_wire};
    end
  end
  always @(negedge i_mdc) begin
    o_drive <= hdr[11:5] == {2'b10, ADR} && cnt >= 7'd47;
    o_data <= (cnt == 7'd47) ? 1'b0 : rv[7'd63 - cnt];
  end
endmodule
`default_nettype wire

// ===== sim/testbench.sv
/* Register-level bench of the user-access channel with a PHY model.
   Assumes a pulled-up shared data pin. */
`timescale 1ns/100ps
`default_nettype none
`include "mdio_uac_regs.vh"
module testbench;
  localparam logic [4:0] PHY = 5'h03;
  logic i_clk_sys, i_rst, psel, penable, pwrite, link, slv;
  logic pready, pslverr, irq, mdc, mdio_o, oe_n, drv, dat;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] regs [3] = '{`OFS_CMD, `OFS_SEL, `OFS_IRQ_STAT};
  wire logic mdio;
  int n_mismatch, tests_run, cyc;
  // Pin level: device first, then PHY, else pull-up.
  assign mdio = !oe_n ? mdio_o : (drv ? dat : 1'b1);
  mdio_user_access_channel mdio_user_access_channel_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_irq(irq), .o_mdc(mdc),
    .i_mdio(mdio), .o_mdio(mdio_o), .o_mdio_oe_n(oe_n));
  phy_model #(.ADR(PHY)) phy_model_i (.i_mdc(mdc), .i_wire(mdio), .i_link(link), .o_drive(drv),
    .o_data(dat));
  // Free-running system clock.
  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  function automatic logic [31:0] cmd(input logic g, w, a, input logic [4:0] r, p,
    input logic [15:0] d);
    return {g, w, a, 3'h0, r, p, d};
  endfunction
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic finish_test;
    if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk_sys);
    penable <= 1'b1;
    @(posedge i_clk_sys);
    // Only the run's ceiling ends a wait for the answer.
    while (pready !== 1'b1) begin
      @(posedge i_clk_sys);
    end
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_clk_sys);
  endtask
  task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
    int n;
    n = 0;
    apb(1'b0, a, 32'h0);
    while (rd[b] !== v && n < 9000) begin
      n++;
      apb(1'b0, a, 32'h0);
    end
  endtask
  // Ceiling on the whole run.
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 95000) begin
      n_mismatch++;
      finish_test();
    end
  end
  // Main sequence.
  initial begin
    {psel, penable, pwrite, link} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    i_rst = 1'b1;
    repeat (10) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    @(posedge i_clk_sys);
    foreach (regs[i]) begin
      apb(1'b0, regs[i], 32'h0);
      chk("reset value", rd, 32'h0);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", {slv, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, `OFS_CMD, cmd(1, 1, 0, 5'h05, PHY, 16'ha5c3));
    apb(1'b0, `OFS_CMD, 32'h0);
    chk("go while off", rd, cmd(0, 1, 0, 5'h05, PHY, 16'ha5c3));
    apb(1'b1, `OFS_CTRL, 32'h1);
    apb(1'b1, `OFS_IRQ_MASK, 32'h2);
    apb(1'b1, `OFS_CMD, cmd(1, 1, 0, 5'h05, PHY, 16'ha5c3));
    apb(1'b1, `OFS_CMD, cmd(0, 0, 0, 5'h09, 5'h09, 16'h0000));
    apb(1'b0, `OFS_CMD, 32'h0);
    chk("write blocked", rd, cmd(1, 1, 0, 5'h05, PHY, 16'ha5c3));
    chk("go kept", {31'h0, rd[31]}, 32'h1);
    wait_bit(`OFS_CMD, 31, 1'b0);
    chk("go cleared", rd, cmd(0, 1, 0, 5'h05, PHY, 16'ha5c3));
    chk("phy register", {16'h0, phy_model_i.mem[5]}, 32'h0000_a5c3);
    apb(1'b0, `OFS_IRQ_STAT, 32'h0);
    chk("done masked", {rd[30:0], irq}, 32'h2);
    apb(1'b1, `OFS_IRQ_MASK, 32'h3);
    chk("irq high", {31'h0, irq}, 32'h1);
    apb(1'b1, `OFS_IRQ_STAT, 32'h1);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    apb(1'b1, `OFS_CMD, cmd(1, 0, 0, 5'h05, PHY, 16'h0000));
    wait_bit(`OFS_CMD, 31, 1'b0);
    chk("read back", rd, cmd(0, 0, 1, 5'h05, PHY, 16'ha5c3));
    apb(1'b1, `OFS_CMD, cmd(1, 0, 1, 5'h05, PHY + 5'h01, 16'h0000));
    wait_bit(`OFS_CMD, 31, 1'b0);
    chk("no ack", {31'h0, rd[29]}, 32'h0);
    apb(1'b1, `OFS_SEL, {25'h0, 2'b10, PHY});
    link <= 1'b1;
    wait_bit(`OFS_IRQ_STAT, 1, 1'b1);
    chk("link event", {31'h0, rd[1]}, 32'h1);
    chk("link irq", {31'h0, irq}, 32'h1);
    apb(1'b0, `OFS_LINK, 32'h0);
    chk("link up", {31'h0, rd[0]}, 32'h1);
    apb(1'b0, `OFS_SEL, 32'h0);
    chk("select", rd, {25'h0, 2'b10, PHY});
    apb(1'b1, `OFS_IRQ_STAT, 32'h3);
    apb(1'b1, `OFS_IRQ_MASK, 32'h0);
    apb(1'b1, `OFS_SEL, {27'h0, PHY});
    link <= 1'b0;
    wait_bit(`OFS_LINK, 0, 1'b0);
    chk("link down", {31'h0, rd[0]}, 32'h0);
    apb(1'b0, `OFS_IRQ_STAT, 32'h0);
    chk("no link event", {31'h0, rd[1]}, 32'h0);
    finish_test();
  end
endmodule
bind mdio_user_access_channel mdio_uac_props mdio_uac_props_i (.i_clk_sys(i_clk_sys),
  .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_irq(o_irq),
  .o_mdc(o_mdc), .o_mdio(o_mdio), .o_mdio_oe_n(o_mdio_oe_n));
`default_nettype wire
